/* File: rtl/mtpa_pkg.sv */
package mtpa_pkg;

	// ----------------------------------------------------------------
	// Bus bytes and command codes
	// ----------------------------------------------------------------
	localparam logic [7:0] GC_WR = 8'h00;
	localparam logic [7:0] GC_RD = 8'h01;
	localparam logic [7:0] CMD_ADDR = 8'h10;
	localparam logic [7:0] CMD_WRITE = 8'h12;
	localparam logic [7:0] CMD_READ = 8'h14;

	// ----------------------------------------------------------------
	// Memory geometry and areas (word addresses, one word is two bytes)
	// ----------------------------------------------------------------
	localparam int MEM_BYTES = 2048;
	localparam int MEM_AW = 11;
	localparam logic [14:0] USER2_HI = 15'h03ff;
	localparam logic [14:0] USER2_LO = 15'h0080;
	localparam logic [14:0] CFGB_HI = 15'h007e;
	localparam logic [14:0] CFGB_LO = 15'h0050;
	localparam logic [14:0] RES_HI = 15'h004e;
	localparam logic [14:0] RES_LO = 15'h0040;
	localparam logic [14:0] USER1_HI = 15'h003e;
	localparam logic [14:0] USER1_LO = 15'h0012;
	localparam logic [14:0] CFGA_HI = 15'h0010;
	localparam logic [14:0] CFGA_LO = 15'h0000;
	localparam logic [7:0] ERASED = 8'hff;
	localparam logic [15:0] ADDR_RST = 16'h0000;
	localparam logic [7:0] BYTE_RST = 8'h00;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ = 125;
	localparam int PROG_TIME_NS = 10000;
	localparam int READ_TIME_NS = 200;
	localparam int PROG_CYC = (PROG_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam int READ_CYC = (READ_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam int CNT_W = 11;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic we;
		logic [15:0] addr;
		logic [7:0] wdata;
	} mtpa_req_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_RX = 3'b001,
		ST_ACK = 3'b011,
		ST_TX = 3'b010,
		ST_TXACK = 3'b110
	} mtpa_state_t;

	typedef enum logic [2:0] {
		PH_ADDR = 3'b000,
		PH_CMD = 3'b001,
		PH_AHI = 3'b011,
		PH_ALO = 3'b010,
		PH_WDAT = 3'b110,
		PH_RDAT = 3'b111,
		PH_IGN = 3'b101
	} mtpa_phase_t;

endpackage

/* File: rtl/mtpa_sync.sv */
`timescale 1ns/1ns
`default_nettype none
module mtpa_sync #(
	parameter int WIDTH = 2
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] sync_r;

	// Idle bus level is high, so both stages reset high
	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_bit
			always_ff @(posedge clk_sys or posedge reset) begin
				if (reset) begin
					meta_r[g] <= 1'b1;
					sync_r[g] <= 1'b1;
				end else begin
					meta_r[g] <= din[g];
					sync_r[g] <= meta_r[g];
				end
			end
		end
	endgenerate

	assign dout = sync_r;
endmodule
`default_nettype wire

/* File: rtl/mtpa_mem.sv */
`timescale 1ns/1ns
`default_nettype none
module mtpa_mem (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic req_vld,
	input wire mtpa_pkg::mtpa_req_t req,
	output logic busy,
	output logic done,
	output logic [7:0] rdata
);
	logic [7:0] mem [0:mtpa_pkg::MEM_BYTES-1];
	logic [mtpa_pkg::MEM_BYTES-1:0] written_r, written_nxt;
	mtpa_pkg::mtpa_req_t cur_r, cur_nxt;
	logic busy_r, busy_nxt;
	logic done_r, done_nxt;
	logic [7:0] rdata_r, rdata_nxt;
	logic [mtpa_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
	logic in_range;
	logic [mtpa_pkg::MEM_AW-1:0] idx;
	logic wr_en;

	assign idx = cur_r.addr[mtpa_pkg::MEM_AW-1:0];
	assign in_range = (cur_r.addr[15:mtpa_pkg::MEM_AW] == '0);

	// ----------------------------------------------------------------
	// Access sequencer: busy from acceptance until the access is over
	// ----------------------------------------------------------------
	always_comb begin
		cur_nxt = cur_r;
		busy_nxt = busy_r;
		done_nxt = 1'b0;
		rdata_nxt = rdata_r;
		cnt_nxt = cnt_r;
		written_nxt = written_r;
		wr_en = 1'b0;
		if (!busy_r) begin
			if (req_vld) begin
				cur_nxt = req;
				busy_nxt = 1'b1;
				cnt_nxt = req.we ? mtpa_pkg::CNT_W'(mtpa_pkg::PROG_CYC - 1)
					: mtpa_pkg::CNT_W'(mtpa_pkg::READ_CYC - 1);
			end
		end else if (cnt_r != '0) begin
			cnt_nxt = cnt_r - 1'b1;
		end else begin
			busy_nxt = 1'b0;
			done_nxt = 1'b1;
			if (cur_r.we) begin
				wr_en = in_range;
				if (in_range) begin
					written_nxt[idx] = 1'b1;
				end
			end else begin
				// Cells never programmed read as erased
				rdata_nxt = (in_range && written_r[idx]) ? mem[idx] : mtpa_pkg::ERASED;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			cur_r <= '0;
			busy_r <= 1'b0;
			done_r <= 1'b0;
			rdata_r <= mtpa_pkg::ERASED;
			cnt_r <= '0;
			written_r <= '0;
		end else begin
			cur_r <= cur_nxt;
			busy_r <= busy_nxt;
			done_r <= done_nxt;
			rdata_r <= rdata_nxt;
			cnt_r <= cnt_nxt;
			written_r <= written_nxt;
		end
	end

	// Storage array has no reset; the written flags stand in for it
	always_ff @(posedge clk_sys) begin
		if (wr_en) begin
			mem[idx] <= cur_r.wdata;
		end
	end

	assign busy = busy_r;
	assign done = done_r;
	assign rdata = rdata_r;
endmodule
`default_nettype wire

/* File: rtl/mtpa_i2c_mtp.sv */
`timescale 1ns/1ns
`default_nettype none
// How it works
// - General call command 0x10 followed by two bytes sets the 16-bit memory address.
// - General call command 0x12 followed by one byte programs that byte at the set address.
// - General call command 0x14 makes the device return one byte read from the set address.
// - The acknowledge bits of the address command tell whether the memory is busy.
// - While the memory is busy every command and data phase of these commands is refused.
// - The address register changes only while the memory is idle.
// - A write starts only after an acknowledged command byte and an acknowledged data byte.
// - The read command byte is acknowledged only when the memory can take the read.
// - Word ranges 0x3FF-0x80 and 0x3E-0x12 are plain user storage, freely read and written.
// - Word ranges 0x7E-0x50 and 0x10-0x00 are writable configuration.
// - Writes to word range 0x4E-0x40 are acknowledged but leave the contents unchanged.
module mtpa_i2c_mtp (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_n,
	output logic mem_busy
);
	// ----------------------------------------------------------------
	// Area decoding
	// ----------------------------------------------------------------
	function automatic logic in_area(input logic [15:0] a, input logic [14:0] lo,
		input logic [14:0] hi);
		in_area = (a[15:1] >= lo) && (a[15:1] <= hi);
	endfunction

	function automatic logic write_allowed(input logic [15:0] a);
		write_allowed = in_area(a, mtpa_pkg::USER2_LO, mtpa_pkg::USER2_HI)
			|| in_area(a, mtpa_pkg::USER1_LO, mtpa_pkg::USER1_HI)
			|| in_area(a, mtpa_pkg::CFGB_LO, mtpa_pkg::CFGB_HI)
			|| in_area(a, mtpa_pkg::CFGA_LO, mtpa_pkg::CFGA_HI);
	endfunction

	// ----------------------------------------------------------------
	// Pin sampling and bus conditions
	// ----------------------------------------------------------------
	logic [1:0] pin_s;
	logic scl_s, sda_s;
	logic scl_d_r, sda_d_r;
	logic scl_rise, scl_fall, start_c, stop_c;

	mtpa_sync #(
		.WIDTH(2)
	) u_sync (
		.clk_sys(clk_sys),
		.reset(reset),
		.din({sda_i, scl_i}),
		.dout(pin_s)
	);

	assign scl_s = pin_s[0];
	assign sda_s = pin_s[1];
	assign scl_rise = scl_s && !scl_d_r;
	assign scl_fall = !scl_s && scl_d_r;
	assign start_c = scl_s && scl_d_r && sda_d_r && !sda_s;
	assign stop_c = scl_s && scl_d_r && !sda_d_r && sda_s;

	// ----------------------------------------------------------------
	// Memory access engine
	// ----------------------------------------------------------------
	mtpa_pkg::mtpa_req_t req_r, req_nxt;
	logic req_vld_r, req_vld_nxt;
	logic eng_busy, eng_done;
	logic [7:0] eng_rdata;
	logic busy_any;

	mtpa_mem u_mem (
		.clk_sys(clk_sys),
		.reset(reset),
		.req_vld(req_vld_r),
		.req(req_r),
		.busy(eng_busy),
		.done(eng_done),
		.rdata(eng_rdata)
	);

	// A request just issued counts as busy before the engine takes it
	assign busy_any = eng_busy || req_vld_r;

	// ----------------------------------------------------------------
	// Protocol state
	// ----------------------------------------------------------------
	mtpa_pkg::mtpa_state_t st_r, st_nxt;
	mtpa_pkg::mtpa_phase_t ph_r, ph_nxt;
	logic [3:0] bit_cnt_r, bit_cnt_nxt;
	logic [7:0] sh_r, sh_nxt;
	logic [7:0] addr_hi_r, addr_hi_nxt;
	logic [15:0] addr_r, addr_nxt;
	logic rd_pend_r, rd_pend_nxt;
	logic rd_ok_r, rd_ok_nxt;
	logic oe_n_r, oe_n_nxt;
	logic busy_r, busy_nxt;
	logic ack_c;
	mtpa_pkg::mtpa_phase_t ph_dec;

	// Byte decision: whether to acknowledge and which phase follows
	always_comb begin
		ack_c = 1'b0;
		ph_dec = mtpa_pkg::PH_IGN;
		case (ph_r)
			mtpa_pkg::PH_ADDR: begin
				if (sh_r == mtpa_pkg::GC_WR) begin
					ack_c = 1'b1;
					ph_dec = mtpa_pkg::PH_CMD;
				end else if (sh_r == mtpa_pkg::GC_RD && rd_pend_r) begin
					ack_c = rd_ok_r && !busy_any;
					ph_dec = mtpa_pkg::PH_RDAT;
				end
			end
			mtpa_pkg::PH_CMD: begin
				ack_c = !busy_any;
				if (sh_r == mtpa_pkg::CMD_ADDR) begin
					ph_dec = mtpa_pkg::PH_AHI;
				end else if (sh_r == mtpa_pkg::CMD_WRITE) begin
					ph_dec = mtpa_pkg::PH_WDAT;
				end else if (sh_r != mtpa_pkg::CMD_READ) begin
					ack_c = 1'b0;
				end
			end
			mtpa_pkg::PH_AHI: begin
				ack_c = !busy_any;
				ph_dec = mtpa_pkg::PH_ALO;
			end
			mtpa_pkg::PH_ALO, mtpa_pkg::PH_WDAT: begin
				ack_c = !busy_any;
			end
			default: begin
				ack_c = 1'b0;
			end
		endcase
	end

	always_comb begin
		st_nxt = st_r;
		ph_nxt = ph_r;
		bit_cnt_nxt = bit_cnt_r;
		sh_nxt = sh_r;
		addr_hi_nxt = addr_hi_r;
		addr_nxt = addr_r;
		rd_pend_nxt = rd_pend_r;
		rd_ok_nxt = rd_ok_r;
		oe_n_nxt = oe_n_r;
		req_nxt = req_r;
		req_vld_nxt = 1'b0;
		busy_nxt = busy_any;
		if (eng_done && !req_r.we) begin
			rd_ok_nxt = 1'b1;
		end
		if (start_c) begin
			st_nxt = mtpa_pkg::ST_RX;
			ph_nxt = mtpa_pkg::PH_ADDR;
			bit_cnt_nxt = '0;
			oe_n_nxt = 1'b1;
		end else if (stop_c) begin
			st_nxt = mtpa_pkg::ST_IDLE;
			oe_n_nxt = 1'b1;
		end else begin
			case (st_r)
				mtpa_pkg::ST_IDLE: begin
					oe_n_nxt = 1'b1;
				end
				mtpa_pkg::ST_RX: begin
					if (scl_rise) begin
						sh_nxt = {sh_r[6:0], sda_s};
						bit_cnt_nxt = bit_cnt_r + 1'b1;
					end else if (scl_fall && bit_cnt_r == mtpa_pkg::BITS_PER_BYTE) begin
						st_nxt = mtpa_pkg::ST_ACK;
						ph_nxt = ph_dec;
						oe_n_nxt = !ack_c;
						if (ack_c) begin
							case (ph_r)
								mtpa_pkg::PH_CMD: begin
									if (sh_r == mtpa_pkg::CMD_READ) begin
										// Read starts once its command byte is accepted
										req_nxt.we = 1'b0;
										req_nxt.addr = addr_r;
										req_vld_nxt = 1'b1;
										rd_pend_nxt = 1'b1;
										rd_ok_nxt = 1'b0;
									end
								end
								mtpa_pkg::PH_AHI: begin
									addr_hi_nxt = sh_r;
								end
								mtpa_pkg::PH_ALO: begin
									addr_nxt = {addr_hi_r, sh_r};
								end
								mtpa_pkg::PH_WDAT: begin
									// Reserved words are acknowledged but never programmed
									req_nxt.we = 1'b1;
									req_nxt.addr = addr_r;
									req_nxt.wdata = sh_r;
									req_vld_nxt = write_allowed(addr_r);
								end
								default: begin
									req_vld_nxt = 1'b0;
								end
							endcase
						end
					end
				end
				mtpa_pkg::ST_ACK: begin
					if (scl_fall) begin
						bit_cnt_nxt = '0;
						if (oe_n_r) begin
							st_nxt = mtpa_pkg::ST_IDLE;
						end else if (ph_r == mtpa_pkg::PH_RDAT) begin
							st_nxt = mtpa_pkg::ST_TX;
							sh_nxt = eng_rdata;
							oe_n_nxt = eng_rdata[7];
							rd_pend_nxt = 1'b0;
						end else begin
							st_nxt = mtpa_pkg::ST_RX;
							oe_n_nxt = 1'b1;
						end
					end
				end
				mtpa_pkg::ST_TX: begin
					if (scl_rise) begin
						bit_cnt_nxt = bit_cnt_r + 1'b1;
					end else if (scl_fall) begin
						if (bit_cnt_r == mtpa_pkg::BITS_PER_BYTE) begin
							st_nxt = mtpa_pkg::ST_TXACK;
							oe_n_nxt = 1'b1;
						end else begin
							sh_nxt = {sh_r[6:0], 1'b1};
							oe_n_nxt = sh_r[6];
						end
					end
				end
				mtpa_pkg::ST_TXACK: begin
					if (scl_rise) begin
						// A master that keeps acknowledging gets the same byte again;
						// the line is only taken back once the clock is low again
						bit_cnt_nxt = '0;
						if (sda_s) begin
							st_nxt = mtpa_pkg::ST_IDLE;
						end
					end else if (scl_fall && bit_cnt_r == '0) begin
						st_nxt = mtpa_pkg::ST_TX;
						sh_nxt = eng_rdata;
						oe_n_nxt = eng_rdata[7];
					end
				end
				default: begin
					st_nxt = mtpa_pkg::ST_IDLE;
					oe_n_nxt = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
			st_r <= mtpa_pkg::ST_IDLE;
			ph_r <= mtpa_pkg::PH_ADDR;
			bit_cnt_r <= '0;
			sh_r <= mtpa_pkg::BYTE_RST;
			addr_hi_r <= mtpa_pkg::BYTE_RST;
			addr_r <= mtpa_pkg::ADDR_RST;
			rd_pend_r <= 1'b0;
			rd_ok_r <= 1'b0;
			oe_n_r <= 1'b1;
			req_r <= '0;
			req_vld_r <= 1'b0;
			busy_r <= 1'b0;
		end else begin
			scl_d_r <= scl_s;
			sda_d_r <= sda_s;
			st_r <= st_nxt;
			ph_r <= ph_nxt;
			bit_cnt_r <= bit_cnt_nxt;
			sh_r <= sh_nxt;
			addr_hi_r <= addr_hi_nxt;
			addr_r <= addr_nxt;
			rd_pend_r <= rd_pend_nxt;
			rd_ok_r <= rd_ok_nxt;
			oe_n_r <= oe_n_nxt;
			req_r <= req_nxt;
			req_vld_r <= req_vld_nxt;
			busy_r <= busy_nxt;
		end
	end

	// Open drain: only ever pulls low
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			sda_o <= 1'b0;
		end else begin
			sda_o <= 1'b0;
		end
	end

	assign sda_oe_n = oe_n_r;
	assign mem_busy = busy_r;
endmodule
`default_nettype wire

/* File: sim/mtpa_i2c_mtp_asserts.sv */
`timescale 1ns/1ns
`default_nettype none
module mtpa_i2c_mtp_asserts (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic sda_o,
	input wire logic sda_oe_n,
	input wire logic mem_busy
);
	// ------------------------------------------------
	// Busy length counter and port checks
	// ------------------------------------------------
	logic [11:0] busy_cnt_r;
	logic [11:0] busy_cnt_nxt;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (reset);
	always_comb begin
		busy_cnt_nxt = mem_busy ? busy_cnt_r + 12'h001 : 12'h000;
	end
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			busy_cnt_r <= 12'h000;
		end else begin
			busy_cnt_r <= busy_cnt_nxt;
		end
	end
	a_sda_o_low: assert property (sda_o == 1'b0)
		else $error("sda_o not low");
	a_oe_scl_low: assert property ($changed(sda_oe_n) |-> !scl_i)
		else $error("sda_oe_n moved with scl high");
	a_ack_holds: assert property ($fell(sda_oe_n) |=> (!sda_oe_n) [*8])
		else $error("acknowledge bit too short");
	a_busy_on_ack: assert property ($rose(mem_busy) |-> !sda_oe_n && !scl_i)
		else $error("access started without acknowledge");
	a_busy_min: assert property ($rose(mem_busy) |=> mem_busy [*8])
		else $error("busy dropped early");
	a_busy_max: assert property (int'(busy_cnt_r) <= mtpa_pkg::PROG_CYC + 16)
		else $error("busy held too long");
	a_busy_gap: assert property ($fell(mem_busy) |-> (!mem_busy) [*8])
		else $error("access restarted without command");
	a_reset_idle: assert property ($fell(reset) |-> sda_oe_n && !mem_busy)
		else $error("not idle after reset");
	cover property ($rose(mem_busy) ##40 mem_busy);
	cover property ($rose(mem_busy) ##[20:30] $fell(mem_busy));
	cover property ($fell(sda_oe_n) && !mem_busy);
endmodule
`default_nettype wire

/* File: sim/mtpa_master.sv */
`timescale 1ns/1ns
`default_nettype none
module mtpa_master (
	input wire logic clk_sys,
	input wire logic sda,
	output logic scl,
	output logic sda_rel
);
	// ------------------------------------------------
	// Bus master; SCL stands high between frames
	// ------------------------------------------------
	initial begin
		scl = 1'b1;
		sda_rel = 1'b1;
	end
	task automatic wt(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	// Also serves as repeated start
	task automatic start();
		wt(4);
		sda_rel = 1'b1;
		wt(4);
		scl = 1'b1;
		wt(8);
		sda_rel = 1'b0;
		wt(8);
		scl = 1'b0;
	endtask
	task automatic stop();
		wt(4);
		sda_rel = 1'b0;
		wt(4);
		scl = 1'b1;
		wt(8);
		sda_rel = 1'b1;
		wt(8);
	endtask
	// MSB first, then the ninth bit; released bits read back the wire
	task automatic xfer(input logic [7:0] tx, input logic b9, output logic [7:0] rx,
		output logic ack);
		logic [8:0] v;
		logic [8:0] s;
		v = {tx, b9};
		for (int i = 8; i >= 0; i--) begin
			wt(4);
			sda_rel = v[i];
			wt(4);
			scl = 1'b1;
			wt(8);
			s[i] = sda;
			scl = 1'b0;
		end
		rx = s[8:1];
		ack = ~s[0];
	endtask
endmodule
`default_nettype wire

/* File: sim/tb_mtpa_i2c_mtp.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_mtpa_i2c_mtp;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	wire logic sda;
	logic scl, sda_rel, sda_o, sda_oe_n, mem_busy;
	int n_mismatch = 0;
	int total_checks = 0;
	logic [14:0] lo_w [5];
	logic [14:0] hi_w [5];
	always #4 clk_sys = ~clk_sys;
	// Pull-up wire: whoever pulls low wins
	assign sda = sda_rel & (sda_oe_n | sda_o);
	mtpa_master u_mtpa_master (.clk_sys(clk_sys), .sda(sda), .scl(scl), .sda_rel(sda_rel));
	mtpa_i2c_mtp u_mtpa_i2c_mtp (.clk_sys(clk_sys), .reset(reset), .scl_i(scl), .sda_i(sda),
		.sda_o(sda_o), .sda_oe_n(sda_oe_n), .mem_busy(mem_busy));
	// ------------------------------------------------
	// Helpers
	// ------------------------------------------------
	task automatic report_and_stop();
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	function automatic logic is_res(input logic [15:0] a);
		return a[15:1] >= mtpa_pkg::RES_LO && a[15:1] <= mtpa_pkg::RES_HI;
	endfunction
	// Start, general call, command, nd data bytes high first, stop
	task automatic cmd(input logic [7:0] c, input logic [15:0] d, input int nd, output logic ok);
		logic [7:0] rx;
		logic a;
		u_mtpa_master.start();
		u_mtpa_master.xfer(mtpa_pkg::GC_WR, 1'b1, rx, ok);
		u_mtpa_master.xfer(c, 1'b1, rx, a);
		ok &= a;
		for (int i = nd; i > 0; i--) begin
			u_mtpa_master.xfer(d[i*8-1 -: 8], 1'b1, rx, a);
			ok &= a;
		end
		u_mtpa_master.stop();
	endtask
	task automatic rd(output logic ok, output logic [7:0] rx, output logic [7:0] rx2);
		logic a;
		u_mtpa_master.start();
		u_mtpa_master.xfer(mtpa_pkg::GC_WR, 1'b1, rx, ok);
		u_mtpa_master.xfer(mtpa_pkg::CMD_READ, 1'b1, rx, a);
		ok &= a;
		a = 1'b0;
		for (int t = 0; t < 20 && ok && !a; t++) begin
			u_mtpa_master.start();
			u_mtpa_master.xfer(mtpa_pkg::GC_RD, 1'b1, rx, a);
		end
		if (ok && !a) begin
			n_mismatch++;
			report_and_stop();
		end
		if (a) begin
			// Acknowledge the first byte so that it is sent once more
			u_mtpa_master.xfer(8'hff, 1'b0, rx, a);
			u_mtpa_master.xfer(8'hff, 1'b1, rx2, a);
		end
		u_mtpa_master.stop();
	endtask
	task automatic wait_idle();
		int n;
		n = 0;
		while (mem_busy !== 1'b0 && n < 2000) begin
			@(negedge clk_sys);
			n++;
		end
		if (n == 2000) begin
			n_mismatch++;
			report_and_stop();
		end
	endtask
	// ------------------------------------------------
	// Main sequence
	// ------------------------------------------------
	initial begin
		logic ok;
		logic [7:0] rx, rx2, d;
		logic [15:0] a;
		logic [14:0] w;
		lo_w = '{mtpa_pkg::USER2_LO, mtpa_pkg::CFGB_LO, mtpa_pkg::RES_LO, mtpa_pkg::USER1_LO,
			mtpa_pkg::CFGA_LO};
		hi_w = '{mtpa_pkg::USER2_HI, mtpa_pkg::CFGB_HI, mtpa_pkg::RES_HI, mtpa_pkg::USER1_HI,
			mtpa_pkg::CFGA_HI};
		void'($urandom(87533));
		repeat (8) @(negedge clk_sys);
		reset = 1'b0;
		chk("oe_n reset", {7'h00, sda_oe_n}, 8'h01);
		chk("busy reset", {7'h00, mem_busy}, 8'h00);
		repeat (4) @(negedge clk_sys);
		cmd(8'h16, 16'h0000, 0, ok);
		chk("unknown cmd", {7'h00, ok}, 8'h00);
		// Read phase with no read command before it is refused
		u_mtpa_master.start();
		u_mtpa_master.xfer(mtpa_pkg::GC_RD, 1'b1, rx, ok);
		u_mtpa_master.stop();
		chk("read unarmed", {7'h00, ok}, 8'h00);
		// Area boundaries first, then random words
		for (int k = 0; k < 15; k++) begin
			w = k < 5 ? lo_w[k] : k < 10 ? hi_w[k%5] :
				lo_w[k%5] + 15'($urandom % (hi_w[k%5] - lo_w[k%5] + 15'h0001));
			a = {w, 1'($urandom)};
			d = 8'($urandom);
			cmd(mtpa_pkg::CMD_ADDR, a, 2, ok);
			chk("addr ack", {7'h00, ok}, 8'h01);
			cmd(mtpa_pkg::CMD_WRITE, {8'h00, d}, 1, ok);
			chk("write ack", {7'h00, ok}, 8'h01);
			if (!is_res(a)) begin
				chk("busy write", {7'h00, mem_busy}, 8'h01);
				cmd(mtpa_pkg::CMD_ADDR, ~a, 2, ok);
				chk("addr busy", {7'h00, ok}, 8'h00);
				rd(ok, rx, rx2);
				chk("read busy", {7'h00, ok}, 8'h00);
			end
			wait_idle();
			rd(ok, rx, rx2);
			chk("read ack", {7'h00, ok}, 8'h01);
			chk("read data", rx, is_res(a) ? mtpa_pkg::ERASED : d);
			chk("read repeat", rx2, is_res(a) ? mtpa_pkg::ERASED : d);
		end
		report_and_stop();
	end
endmodule
bind mtpa_i2c_mtp mtpa_i2c_mtp_asserts u_mtpa_i2c_mtp_asserts (.clk_sys(clk_sys), .reset(reset),
	.scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .mem_busy(mem_busy));
`default_nettype wire
